// File: digital_input_defines.vh
/*
  constants for the digital input channel: register offsets, field positions,
  reset values, selector codes and the time base.
  assumes a 10 MHz system clock and a 32-bit AHB-Lite register port.
*/
`ifndef DIGITAL_INPUT_DEFINES_VH
`define DIGITAL_INPUT_DEFINES_VH

`define CLK_FREQ_HZ 10000000
`define TICK_PERIOD_S 1
`define TICK_CYCLES 24'h989680
`define HOUR_S 12'hE10

`define OFS_CTRL 8'h00
`define OFS_DELAY 8'h04
`define OFS_WEIGHT 8'h08
`define OFS_FACTOR 8'h0C
`define OFS_TOTAL 8'h10
`define OFS_OPTIME 8'h14
`define OFS_LABEL_LO 8'h18
`define OFS_LABEL_HI 8'h1C
`define OFS_STATUS 8'h20
`define OFS_INT_STAT 8'h24
`define OFS_INT_MASK 8'h28

`define CTRL_FUNC_LSB 0
`define CTRL_ACTION_LSB 3
`define CTRL_BUSFUNC_LSB 6
`define CTRL_PER_HOUR_BIT 9
`define CTRL_DECIMALS_LSB 10
`define CTRL_RELAY_LSB 13
`define CTRL_RESET 32'h00000400

`define DELAY_RESET 17'h00000
`define DELAY_MAX 17'h1869F
`define WEIGHT_RESET 32'h00000001
`define FACTOR_RESET 32'h00000001
`define LABEL_LO_RESET 32'h00006E4F
`define LABEL_HI_RESET 16'h0000

`define FN_OFF 3'h0
`define FN_CONTROL 3'h1
`define FN_EVENT 3'h2
`define FN_PULSE 3'h3
`define FN_OPTIME 3'h4
`define FN_EVENT_TIME 3'h5
`define FN_QUANTITY 3'h6
`define FN_FIELDBUS 3'h7

`define ACT_OFF 3'h0
`define ACT_RECORD 3'h1
`define ACT_SCREEN 3'h2
`define ACT_BLOCK_SETUP 3'h3
`define ACT_TIME_SYNC 3'h4
`define ACT_SETPOINT 3'h5
`define ACT_BLOCK_KEYS 3'h6
`define ACT_ANALYSIS 3'h7

`define IRQ_RISE_BIT 0
`define IRQ_FALL_BIT 1
`define IRQ_SYNC_BIT 2
`define IRQ_WRAP_BIT 3
`define ROUND_UP_SEC 6'h1E

`endif

// File: digital_input_channel.v
/*
  one high-active digital input channel: input qualification, control actions,
  pulse and time totalizers, relay drive, label and an AHB-Lite register port
  with a masked level interrupt.
  assumes inputs synchronous to mclk apart from the field contact, a single
  AHB-Lite master of whole-word single transfers, and a seconds value from the
  system clock for time synchronization.
*/
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`include "digital_input_defines.vh"
`default_nettype none

// Summary of operation
// (RULE1) high input level is the active state
// (RULE2) eight-way function selector, off after reset
// (RULE3) rise qualified after programmed seconds of high
// (RULE4) fall follows raw low immediately
// (RULE5) recording only while qualified input high
// (RULE6) display and backlight follow input level
// (RULE7) setup changes allowed only while low
// (RULE8) rising edge rounds time to nearest minute
// (RULE9) keys accepted only while input low
// (RULE10) setpoint monitoring enabled while input high
// (RULE11) analysis runs while high, trend recording continues
// (RULE12) each pulse adds programmed weight to total
// (RULE13) rate factor times active time, second/hour base
// (RULE14) total shown with zero to five decimals
// (RULE15) assigned relay follows qualified state
// (RULE16) fieldbus slave uses second function selector
// (RULE17) six-character active label shown and recorded
// (RULE18) input synchronised; delay restarts on early low
module digital_input_channel #(
  parameter [23:0] TICK_CYCLES = `TICK_CYCLES
) (
  input wire mclk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire irq,
  input wire field_in,
  input wire bus_level,
  input wire [5:0] sys_seconds,
  output reg record_enable,
  output reg display_on,
  output reg setup_permit,
  output reg keys_accept,
  output reg setpoint_enable,
  output reg analysis_run,
  output reg time_sync_pulse,
  output reg time_round_up,
  output reg event_active,
  output reg [5:0] relay_drive,
  output reg [2:0] decimal_places,
  output reg [47:0] active_label,
  output reg label_record
);

  function [31:0] w1c;
    input [31:0] cur;
    input [31:0] set;
    input [31:0] clr;
    begin
      w1c = set | (cur & ~clr);
    end
  endfunction

  // one decode shared by every control action output
  function act_is;
    input sel_ctrl;
    input [2:0] act;
    input [2:0] want;
    begin
      act_is = sel_ctrl && (act == want);
    end
  endfunction

  reg [31:0] ctrl_reg;
  reg [16:0] delay_reg;
  reg [31:0] weight_reg;
  reg [31:0] factor_reg;
  reg [31:0] total_reg;
  reg [31:0] optime_reg;
  reg [31:0] label_lo_reg;
  reg [15:0] label_hi_reg;
  reg [3:0] int_stat_reg;
  reg [3:0] int_mask_reg;

  reg meta_reg;
  reg sync_reg;
  reg src_prev_reg;
  reg qual_reg;
  reg [23:0] dly_cyc_reg;
  reg [16:0] dly_sec_reg;
  reg [23:0] tick_cnt_reg;
  reg [11:0] hour_cnt_reg;

  reg aphase_reg;
  reg aread_reg;
  reg [7:0] aaddr_reg;
  reg wait_reg;

  wire [2:0] func = ctrl_reg[`CTRL_FUNC_LSB +: 3];
  wire [2:0] action = ctrl_reg[`CTRL_ACTION_LSB +: 3];
  wire [2:0] bus_func = ctrl_reg[`CTRL_BUSFUNC_LSB +: 3];
  wire per_hour = ctrl_reg[`CTRL_PER_HOUR_BIT];
  wire [2:0] relay_sel = ctrl_reg[`CTRL_RELAY_LSB +: 3];

  // fieldbus slave mode swaps in the second selector and the bus-fed level
  wire from_bus = (func == `FN_FIELDBUS); // RULE16
  wire [2:0] eff_func = from_bus ? ((bus_func == `FN_FIELDBUS) ? `FN_OFF : bus_func) : func;
  // bus_level is taken as synchronous; only the field contact is synchronised
  wire src = from_bus ? bus_level : sync_reg; // RULE1
  wire delayed = (eff_func == `FN_CONTROL) || (eff_func == `FN_EVENT) ||
                 (eff_func == `FN_EVENT_TIME); // RULE3
  // one free-running seconds tick shared by operating time and totals
  wire tick = (tick_cnt_reg == TICK_CYCLES - 24'h000001);
  wire sec_full = (dly_sec_reg >= delay_reg);

  reg qual_next;
  reg [16:0] dly_sec_next;
  reg [23:0] dly_cyc_next;

  // the delay counter runs on its own phase so the delay starts at the rise,
  // not at the next shared second boundary
  always @* begin
    qual_next = qual_reg;
    dly_sec_next = dly_sec_reg;
    dly_cyc_next = dly_cyc_reg;
    if (eff_func == `FN_OFF) begin
      qual_next = 1'b0;
      dly_sec_next = 17'h00000;
      dly_cyc_next = 24'h000000;
    end else if (!src) begin
      qual_next = 1'b0; // RULE4
      dly_sec_next = 17'h00000; // RULE18
      dly_cyc_next = 24'h000000;
    end else if (!qual_reg) begin
      if (!delayed || sec_full) begin
        qual_next = 1'b1; // RULE3
      end else if (dly_cyc_reg == TICK_CYCLES - 24'h000001) begin
        dly_cyc_next = 24'h000000;
        dly_sec_next = dly_sec_reg + 17'h00001;
      end else begin
        dly_cyc_next = dly_cyc_reg + 24'h000001;
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      src_prev_reg <= 1'b0;
      qual_reg <= 1'b0;
      dly_sec_reg <= 17'h00000;
      dly_cyc_reg <= 24'h000000;
      tick_cnt_reg <= 24'h000000;
    end else begin
      meta_reg <= field_in; // RULE18
      sync_reg <= meta_reg;
      src_prev_reg <= src;
      qual_reg <= qual_next;
      dly_sec_reg <= dly_sec_next;
      dly_cyc_reg <= dly_cyc_next;
      tick_cnt_reg <= tick ? 24'h000000 : tick_cnt_reg + 24'h000001;
    end
  end

  wire rise = qual_next && !qual_reg;
  wire fall = !qual_next && qual_reg;
  wire is_ctrl = (eff_func == `FN_CONTROL);
  wire pulse_edge = (eff_func == `FN_PULSE) && src && !src_prev_reg;
  wire time_on = qual_reg && tick &&
                 ((eff_func == `FN_OPTIME) || (eff_func == `FN_EVENT_TIME));
  wire qty_on = qual_reg && tick && (eff_func == `FN_QUANTITY);
  wire hour_due = per_hour && (hour_cnt_reg == `HOUR_S - 12'h001);
  wire qty_add = qty_on && (!per_hour || hour_due);
  wire [32:0] pulse_sum = {1'b0, total_reg} + {1'b0, weight_reg};
  wire [32:0] qty_sum = {1'b0, total_reg} + {1'b0, factor_reg};

  // AHB-Lite: writes complete with no wait, reads take one wait state so a
  // read right behind a write still sees the new value
  wire take = hsel && hready && htrans[1];
  wire wr_ph = aphase_reg && !aread_reg;
  wire rd_ph = aphase_reg && aread_reg;
  assign hreadyout = !(rd_ph && !wait_reg);
  assign hresp = 1'b0;
  assign irq = |(int_stat_reg & int_mask_reg);

  reg [31:0] rd_mux;
  always @* begin
    case (aaddr_reg)
      `OFS_CTRL: rd_mux = ctrl_reg;
      `OFS_DELAY: rd_mux = {15'h0000, delay_reg};
      `OFS_WEIGHT: rd_mux = weight_reg;
      `OFS_FACTOR: rd_mux = factor_reg;
      `OFS_TOTAL: rd_mux = total_reg;
      `OFS_OPTIME: rd_mux = optime_reg;
      `OFS_LABEL_LO: rd_mux = label_lo_reg;
      `OFS_LABEL_HI: rd_mux = {16'h0000, label_hi_reg};
      `OFS_STATUS: rd_mux = {29'h00000000, !qual_reg && src && delayed, qual_reg, src};
      `OFS_INT_STAT: rd_mux = {28'h0000000, int_stat_reg};
      `OFS_INT_MASK: rd_mux = {28'h0000000, int_mask_reg};
      default: rd_mux = 32'h00000000;
    endcase
  end

  wire wr_ctrl = wr_ph && (aaddr_reg == `OFS_CTRL);
  wire wr_total = wr_ph && (aaddr_reg == `OFS_TOTAL);
  wire wr_optime = wr_ph && (aaddr_reg == `OFS_OPTIME);
  wire wr_istat = wr_ph && (aaddr_reg == `OFS_INT_STAT);
  wire [3:0] ev_set;
  assign ev_set[`IRQ_RISE_BIT] = rise;
  assign ev_set[`IRQ_FALL_BIT] = fall;
  assign ev_set[`IRQ_SYNC_BIT] = rise && act_is(is_ctrl, action, `ACT_TIME_SYNC);
  assign ev_set[`IRQ_WRAP_BIT] = (pulse_edge && pulse_sum[32]) || (qty_add && qty_sum[32]);
  wire [31:0] int_stat_new = w1c({28'h0000000, int_stat_reg}, {28'h0000000, ev_set},
                                 wr_istat ? hwdata : 32'h00000000);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aphase_reg <= 1'b0;
      aread_reg <= 1'b0;
      aaddr_reg <= 8'h00;
      wait_reg <= 1'b0;
      hrdata <= 32'h00000000;
      ctrl_reg <= `CTRL_RESET; // RULE2
      delay_reg <= `DELAY_RESET;
      weight_reg <= `WEIGHT_RESET;
      factor_reg <= `FACTOR_RESET;
      label_lo_reg <= `LABEL_LO_RESET;
      label_hi_reg <= `LABEL_HI_RESET;
      int_mask_reg <= 4'h0;
      int_stat_reg <= 4'h0;
    end else begin
      if (hreadyout) begin
        aphase_reg <= take;
        aread_reg <= take && !hwrite;
        aaddr_reg <= haddr[7:0];
      end
      wait_reg <= rd_ph && !wait_reg;
      if (rd_ph && !wait_reg) begin
        hrdata <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_reg <= {16'h0000, hwdata[15:0]};
      end
      if (wr_ph && aaddr_reg == `OFS_DELAY) begin
        delay_reg <= (hwdata[16:0] > `DELAY_MAX) ? `DELAY_MAX : hwdata[16:0];
      end
      if (wr_ph && aaddr_reg == `OFS_WEIGHT) begin
        weight_reg <= hwdata;
      end
      if (wr_ph && aaddr_reg == `OFS_FACTOR) begin
        factor_reg <= hwdata;
      end
      if (wr_ph && aaddr_reg == `OFS_LABEL_LO) begin
        label_lo_reg <= hwdata;
      end
      if (wr_ph && aaddr_reg == `OFS_LABEL_HI) begin
        label_hi_reg <= hwdata[15:0];
      end
      if (wr_ph && aaddr_reg == `OFS_INT_MASK) begin
        int_mask_reg <= hwdata[3:0];
      end
      // a new event beats a clear written in the same cycle
      int_stat_reg <= int_stat_new[3:0];
    end
  end

  // operating time wraps silently at 32 bits; a total wrap raises an interrupt instead
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      total_reg <= 32'h00000000;
      optime_reg <= 32'h00000000;
      hour_cnt_reg <= 12'h000;
    end else begin
      if (wr_total) begin
        total_reg <= hwdata;
      end else if (pulse_edge) begin
        total_reg <= pulse_sum[31:0]; // RULE12
      end else if (qty_add) begin
        total_reg <= qty_sum[31:0]; // RULE13
      end
      // per-hour mode adds the whole factor once per 3600 active seconds
      if (qty_on && per_hour) begin
        hour_cnt_reg <= hour_due ? 12'h000 : hour_cnt_reg + 12'h001; // RULE13
      end
      if (wr_optime) begin
        optime_reg <= hwdata;
      end else if (time_on || qty_on) begin
        optime_reg <= optime_reg + 32'h00000001;
      end
    end
  end

  // actions fall back to their permissive state when not selected
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      record_enable <= 1'b1;
      display_on <= 1'b1;
      setup_permit <= 1'b1;
      keys_accept <= 1'b1;
      setpoint_enable <= 1'b1;
      analysis_run <= 1'b1;
      time_sync_pulse <= 1'b0;
      time_round_up <= 1'b0;
      event_active <= 1'b0;
      relay_drive <= 6'h00;
      decimal_places <= 3'h1;
      active_label <= 48'h000000000000;
      label_record <= 1'b0;
    end else begin
      record_enable <= !act_is(is_ctrl, action, `ACT_RECORD) || qual_reg; // RULE5
      display_on <= !act_is(is_ctrl, action, `ACT_SCREEN) || qual_reg; // RULE6
      setup_permit <= !act_is(is_ctrl, action, `ACT_BLOCK_SETUP) || !qual_reg; // RULE7
      keys_accept <= !act_is(is_ctrl, action, `ACT_BLOCK_KEYS) || !qual_reg; // RULE9
      setpoint_enable <= !act_is(is_ctrl, action, `ACT_SETPOINT) || qual_reg; // RULE10
      analysis_run <= !act_is(is_ctrl, action, `ACT_ANALYSIS) || qual_reg; // RULE11
      time_sync_pulse <= ev_set[`IRQ_SYNC_BIT]; // RULE8
      time_round_up <= ev_set[`IRQ_SYNC_BIT] ? (sys_seconds >= `ROUND_UP_SEC)
                                              : time_round_up; // RULE8
      event_active <= qual_reg && delayed;
      // relay code 7 names no relay, so it drives nothing
      relay_drive <= (relay_sel != 3'h0 && relay_sel <= 3'h6 && delayed)
                     ? ({5'h00, qual_reg} << (relay_sel - 3'h1)) : 6'h00; // RULE15
      decimal_places <= (ctrl_reg[`CTRL_DECIMALS_LSB +: 3] > 3'h5)
                        ? 3'h5 : ctrl_reg[`CTRL_DECIMALS_LSB +: 3]; // RULE14
      active_label <= {label_hi_reg, label_lo_reg}; // RULE17
      label_record <= qual_reg && delayed && record_enable; // RULE17
    end
  end

endmodule

`default_nettype wire

// File: field_contact_model.sv
/*
  field contact model: drives the raw input of one digital channel.
  assumes the bench calls its tasks and one clock mclk.
*/
`default_nettype none
module field_contact_model (
  input wire logic mclk,
  output logic field_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial field_in = 1'b0;
  // contact closes high; changes only just after an edge
  task automatic pulse(input int hi, input int lo);
    @(posedge mclk);
    field_in <= 1'b1;
    repeat (hi) @(posedge mclk);
    field_in <= 1'b0;
    repeat (lo) @(posedge mclk);
  endtask
  task automatic level(input logic v);
    @(posedge mclk);
    field_in <= v;
  endtask
endmodule
`default_nettype wire

// File: digital_input_channel_chk.sv
/*
  assertions on the digital input channel outputs.
  assumes binding to the channel top with mclk and rst_n.
*/
`default_nettype none
module digital_input_channel_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic field_in,
  input wire logic [5:0] sys_seconds,
  input wire logic record_enable,
  input wire logic display_on,
  input wire logic setup_permit,
  input wire logic keys_accept,
  input wire logic time_sync_pulse,
  input wire logic time_round_up,
  input wire logic event_active,
  input wire logic [5:0] relay_drive,
  input wire logic [2:0] decimal_places
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_low5;
    !field_in [*5];
  endsequence
  sequence s_sync;
    time_round_up == ($past(sys_seconds) >= 6'h1E) ##1 (event_active && !time_sync_pulse);
  endsequence
  a_fall_fast: assert property (s_low5 |-> !event_active)
    else $error("state high after input low");
  // sync plus output stage may add one cycle, so two depths are allowed
  a_rise_cause: assert property (
    $rose(event_active) |-> $past(field_in, 3) || $past(field_in, 4))
    else $error("state rose without input high");
  a_record_gate: assert property (!record_enable |-> !event_active)
    else $error("recording stopped while high");
  a_screen_gate: assert property (!display_on |-> !event_active)
    else $error("display off while high");
  a_setup_gate: assert property (!setup_permit |-> event_active)
    else $error("setup blocked while low");
  a_keys_gate: assert property (!keys_accept |-> event_active)
    else $error("keys blocked while low");
  a_relay_follow: assert property (
    relay_drive != 6'h00 |-> event_active && $onehot(relay_drive))
    else $error("relay on while low");
  a_sync_round: assert property (time_sync_pulse |-> s_sync)
    else $error("time rounding wrong");
  a_decimals_max: assert property (decimal_places <= 3'h5)
    else $error("decimals above five");
endmodule
`default_nettype wire

// File: digital_input_channel_bench.sv
/*
  self-checking bench for the digital input channel with a contact model.
  assumes the defines header; the second tick is shortened to 10 cycles.
*/
`include "digital_input_defines.vh"
`default_nettype none
module digital_input_channel_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, bus_level = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2, decimal_places;
  logic [5:0] sys_seconds = 0, relay_drive, act_v, e;
  logic hreadyout, hresp, irq, field_in, time_sync_pulse, time_round_up, event_active;
  logic record_enable, display_on, setup_permit, keys_accept, setpoint_enable, analysis_run;
  logic label_record;
  logic [47:0] active_label;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h28, 8'h40};
  logic [31:0] rv [7] = '{`CTRL_RESET, 32'h0, `WEIGHT_RESET, `FACTOR_RESET,
    `LABEL_LO_RESET, 32'h0, 32'h0};
  int n_mismatch = 0, check_count = 0, w, n, k, cnt;
  always #50 mclk = ~mclk;
  assign hready = hreadyout;
  assign act_v = {record_enable, display_on, setup_permit, keys_accept, setpoint_enable,
    analysis_run};
  digital_input_channel #(.TICK_CYCLES(24'h00000A)) DUT (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .field_in(field_in),
    .bus_level(bus_level), .sys_seconds(sys_seconds), .record_enable(record_enable),
    .display_on(display_on), .setup_permit(setup_permit), .keys_accept(keys_accept),
    .setpoint_enable(setpoint_enable), .analysis_run(analysis_run),
    .time_sync_pulse(time_sync_pulse), .time_round_up(time_round_up),
    .event_active(event_active), .relay_drive(relay_drive),
    .decimal_places(decimal_places), .active_label(active_label),
    .label_record(label_record));
  field_contact_model src (.mclk(mclk), .field_in(field_in));
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_ready;
    cnt = 0;
    do begin
      @(posedge mclk);
      cnt++;
      if (cnt > 50) begin
        n_mismatch++;
        end_sim;
      end
    end while (hreadyout !== 1'b1);
  endtask
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
  endtask
  initial begin
    #5000000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    w = $urandom(63);
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      xfer(ra[i], 1'b0, 32'h0);
      compare(rd, rv[i]);
    end
    compare({29'h0, decimal_places}, 32'h1);
    compare(active_label[31:0], `LABEL_LO_RESET);
    w = $urandom % 1000 + 1;
    n = 3 + $urandom % 5;
    xfer(`OFS_CTRL, 1'b1, {29'h0, `FN_PULSE});
    xfer(`OFS_WEIGHT, 1'b1, 32'(w));
    xfer(`OFS_TOTAL, 1'b1, 32'h0);
    // one- and two-cycle pulses with three-cycle gaps, narrow enough to test what the synchroniser can still see
    for (int i = 0; i < n; i++) src.pulse(1 + i % 2, 2);
    cyc(5);
    xfer(`OFS_TOTAL, 1'b0, 32'h0);
    compare(rd, 32'(n * w));
    xfer(`OFS_CTRL, 1'b1, 32'h00006409);
    xfer(`OFS_DELAY, 1'b1, 32'h2);
    src.pulse(15, 0);
    fork
      src.pulse(40, 8);
      begin
        k = 0;
        while (event_active !== 1'b1 && k < 40) begin
          @(posedge mclk);
          k++;
        end
        compare(32'(k >= 20 && k <= 26), 32'h1);
        compare({26'h0, relay_drive}, 32'h4);
        compare({31'h0, record_enable}, 32'h1);
      end
    join
    compare({30'h0, record_enable, event_active}, 32'h0);
    xfer(`OFS_INT_MASK, 1'b1, 32'h2);
    cyc(1);
    compare({31'h0, irq}, 32'h1);
    xfer(`OFS_INT_STAT, 1'b1, 32'h2);
    cyc(1);
    compare({31'h0, irq}, 32'h0);
    xfer(`OFS_INT_STAT, 1'b0, 32'h0);
    compare(rd, 32'h1);
    xfer(`OFS_DELAY, 1'b1, 32'h0);
    for (int a = 1; a < 8; a++) begin
      sys_seconds <= 6'($urandom % 60);
      xfer(`OFS_CTRL, 1'b1, 32'(a * 8 + 1));
      for (int l = 1; l >= 0; l--) begin
        src.level(l[0]);
        cyc(6);
        e = 6'h3F;
        case (a)
          1: e[5] = l[0];
          2: e[4] = l[0];
          3: e[3] = !l[0];
          5: e[1] = l[0];
          6: e[2] = !l[0];
          7: e[0] = l[0];
          default: e = 6'h3F;
        endcase
        compare({26'h0, act_v}, {26'h0, e});
        compare({31'h0, event_active}, 32'(l));
        compare({31'h0, label_record}, 32'(l));
        if (a == 4 && l == 1)
          compare({31'h0, time_round_up}, 32'(sys_seconds >= 6'h1E));
      end
    end
    xfer(`OFS_CTRL, 1'b1, {29'h0, `FN_QUANTITY});
    w = $urandom % 100 + 1;
    xfer(`OFS_FACTOR, 1'b1, 32'(w));
    xfer(`OFS_TOTAL, 1'b1, 32'h0);
    xfer(`OFS_OPTIME, 1'b1, 32'h0);
    src.pulse(45, 5);
    xfer(`OFS_OPTIME, 1'b0, 32'h0);
    n = rd;
    compare(32'(n > 2), 32'h1);
    xfer(`OFS_TOTAL, 1'b0, 32'h0);
    compare(rd, 32'(n * w));
    xfer(`OFS_CTRL, 1'b1, 32'h00000206);
    xfer(`OFS_TOTAL, 1'b1, 32'h0);
    xfer(`OFS_OPTIME, 1'b1, 32'h0);
    // a little over one hour of active time at the shortened tick
    src.pulse(36100, 5);
    xfer(`OFS_OPTIME, 1'b0, 32'h0);
    n = rd;
    compare(32'(n >= 3600 && n < 7200), 32'h1);
    xfer(`OFS_TOTAL, 1'b0, 32'h0);
    compare(rd, 32'(n / 3600 * w));
    xfer(`OFS_CTRL, 1'b1, 32'h00001C00);
    cyc(2);
    compare({29'h0, decimal_places}, 32'h5);
    // fieldbus slave as on/off event: bus_level, not the contact, is the source
    src.level(1'b1);
    xfer(`OFS_CTRL, 1'b1, 32'h00000087);
    cyc(4);
    compare({31'h0, event_active}, 32'h0);
    bus_level <= 1'b1;
    cyc(4);
    compare({31'h0, event_active}, 32'h1);
    end_sim;
  end
endmodule
bind digital_input_channel digital_input_channel_chk chk (.mclk(mclk), .rst_n(rst_n),
  .field_in(field_in), .sys_seconds(sys_seconds), .record_enable(record_enable),
  .display_on(display_on), .setup_permit(setup_permit), .keys_accept(keys_accept),
  .time_sync_pulse(time_sync_pulse), .time_round_up(time_round_up),
  .event_active(event_active), .relay_drive(relay_drive), .decimal_places(decimal_places));
`default_nettype wire
